/* logic/adc_setup_regs.sv */
// Setup configuration and excitation routing register bank.
// Assumes a same-clock register master: one-cycle strobes, read data next cycle.
//
// Overview of operation
// - Source 1 pin codes 0,1,4,5,a,b,e,f pick inputs 0-7; others reserved.
// - Channel 0 bits 3:0 route source 0, same codes; reserved elsewhere.
// - Eight setup registers at 0x19 to 0x20, reset zero, read and write.
// - Each setup bundles all settings; channels pick a setup, sharing allowed.
// - Setup bits 15:13 set source 1 magnitude: off, 10 uA up to 200 uA, or 100 nA.
// - Setup bits 12:10 set source 0 magnitude, same table, zero off.
// - Setup bits 9:8 pick burnout current: off, 0.5, 2, 4 uA.
// - Setup bit 7 set turns positive reference buffer on, clear bypasses.
// - Setup bit 6 holds negative reference buffer control, reset zero, RW.
// - Negative buffer bit zero bypasses, one turns the buffer on.
`timescale 1ns/100ps
module adc_setup_regs
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] addr,
    input wire logic [15:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [15:0] rd_data,
    input wire logic [2:0] active_channel,
    output adc_setup_pkg::exc_level_t exc1_magnitude,
    output adc_setup_pkg::exc_level_t exc0_magnitude,
    output adc_setup_pkg::burnout_level_t burnout_level,
    output logic pos_ref_buffer_on,
    output logic neg_ref_buffer_on,
    output logic [7:0] exc1_pin_select,
    output logic [7:0] exc0_pin_select,
    output logic exc1_pin_reserved,
    output logic exc0_pin_reserved
);
    logic [7:0][15:0] setup_r;
    logic [7:0][15:0] setup_nxt;
    logic [7:0][15:0] chan_r;
    logic [7:0][15:0] chan_nxt;
    logic [15:0] rd_data_r;
    logic [15:0] rd_data_nxt;
    logic [15:0] rd_mux;
    logic setup_hit;
    logic chan_hit;
    logic [2:0] setup_idx;
    logic [2:0] chan_idx;
    logic [2:0] cur_setup;
    logic [15:0] cur_cfg;

    logic [2:0] exc1_mag_r;
    logic [2:0] exc1_mag_nxt;
    logic [2:0] exc0_mag_r;
    logic [2:0] exc0_mag_nxt;
    logic [1:0] burn_r;
    logic [1:0] burn_nxt;
    logic pos_buf_r;
    logic pos_buf_nxt;
    logic neg_buf_r;
    logic neg_buf_nxt;
    logic [7:0] exc1_pin_r;
    logic [7:0] exc1_pin_nxt;
    logic [7:0] exc0_pin_r;
    logic [7:0] exc0_pin_nxt;
    logic exc1_rsv_r;
    logic exc1_rsv_nxt;
    logic exc0_rsv_r;
    logic exc0_rsv_nxt;

    pin_sel_if ps[2]();

    // Address decode
    always_comb
    begin
        setup_hit = (addr >= adc_setup_pkg::SETUP_BASE) && (addr <= adc_setup_pkg::SETUP_LAST);
        chan_hit = (addr >= adc_setup_pkg::CHAN_BASE) && (addr <= adc_setup_pkg::CHAN_LAST);
        setup_idx = 3'(addr - adc_setup_pkg::SETUP_BASE);
        chan_idx = 3'(addr - adc_setup_pkg::CHAN_BASE);
    end

    // Register file next state
    always_comb
    begin
        setup_nxt = setup_r;
        chan_nxt = chan_r;
        if (ce && wr_en && setup_hit)
        begin
            setup_nxt[setup_idx] = wr_data;
        end
        // source 0 field only in channel 0
        if (ce && wr_en && chan_hit)
        begin
            if (chan_idx == 3'h0)
            begin
                chan_nxt[chan_idx] = wr_data & adc_setup_pkg::CHAN0_MASK;
            end
            else
            begin
                chan_nxt[chan_idx] = wr_data & adc_setup_pkg::CHANM_MASK;
            end
        end
    end

    // Read path; unmapped addresses read zero
    always_comb
    begin
        if (setup_hit)
        begin
            rd_mux = setup_r[setup_idx];
        end
        else if (chan_hit)
        begin
            rd_mux = chan_r[chan_idx];
        end
        else
        begin
            rd_mux = adc_setup_pkg::READ_ZERO;
        end
        rd_data_nxt = rd_data_r;
        if (ce)
        begin
            rd_data_nxt = rd_en ? rd_mux : adc_setup_pkg::READ_ZERO;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            setup_r <= {adc_setup_pkg::NUM_SETUPS{adc_setup_pkg::SETUP_RST}};
            chan_r <= {adc_setup_pkg::NUM_CHANS{adc_setup_pkg::CHAN_RST}};
            rd_data_r <= adc_setup_pkg::READ_ZERO;
        end
        else
        begin
            setup_r <= setup_nxt;
            chan_r <= chan_nxt;
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_data = rd_data_r;

    // pin code decoders for both sources
    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_src
            if (g == 1)
            begin : g_one
                assign ps[g].code = chan_r[0][adc_setup_pkg::EXC1_PIN_HI:adc_setup_pkg::EXC1_PIN_LO];
            end
            else
            begin : g_zero
                assign ps[g].code = chan_r[0][adc_setup_pkg::EXC0_PIN_HI:adc_setup_pkg::EXC0_PIN_LO];
            end
            pin_code_decoder u_dec
            (
                .sel(ps[g].dec)
            );
        end
    endgenerate

    always_comb
    begin
        cur_setup = chan_r[active_channel][adc_setup_pkg::SETUP_SEL_HI:adc_setup_pkg::SETUP_SEL_LO];
        cur_cfg = setup_r[cur_setup];
    end

    // Analog controls, registered so a write lands in one step
    always_comb
    begin
        exc1_mag_nxt = exc1_mag_r;
        exc0_mag_nxt = exc0_mag_r;
        burn_nxt = burn_r;
        pos_buf_nxt = pos_buf_r;
        neg_buf_nxt = neg_buf_r;
        exc1_pin_nxt = exc1_pin_r;
        exc0_pin_nxt = exc0_pin_r;
        exc1_rsv_nxt = exc1_rsv_r;
        exc0_rsv_nxt = exc0_rsv_r;
        if (ce)
        begin
            exc1_mag_nxt = cur_cfg[adc_setup_pkg::EXC1_MAG_HI:adc_setup_pkg::EXC1_MAG_LO];
            exc0_mag_nxt = cur_cfg[adc_setup_pkg::EXC0_MAG_HI:adc_setup_pkg::EXC0_MAG_LO];
            burn_nxt = cur_cfg[adc_setup_pkg::BURNOUT_HI:adc_setup_pkg::BURNOUT_LO];
            pos_buf_nxt = cur_cfg[adc_setup_pkg::POS_BUF_BIT];
            neg_buf_nxt = cur_cfg[adc_setup_pkg::NEG_BUF_BIT];
            exc1_pin_nxt = ps[1].onehot;
            exc0_pin_nxt = ps[0].onehot;
            exc1_rsv_nxt = !ps[1].valid;
            exc0_rsv_nxt = !ps[0].valid;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            exc1_mag_r <= 3'h0;
            exc0_mag_r <= 3'h0;
            burn_r <= 2'h0;
            pos_buf_r <= 1'b0;
            neg_buf_r <= 1'b0;
            exc1_pin_r <= 8'h00;
            exc0_pin_r <= 8'h00;
            exc1_rsv_r <= 1'b0;
            exc0_rsv_r <= 1'b0;
        end
        else
        begin
            exc1_mag_r <= exc1_mag_nxt;
            exc0_mag_r <= exc0_mag_nxt;
            burn_r <= burn_nxt;
            pos_buf_r <= pos_buf_nxt;
            neg_buf_r <= neg_buf_nxt;
            exc1_pin_r <= exc1_pin_nxt;
            exc0_pin_r <= exc0_pin_nxt;
            exc1_rsv_r <= exc1_rsv_nxt;
            exc0_rsv_r <= exc0_rsv_nxt;
        end
    end

    assign exc1_magnitude = adc_setup_pkg::exc_level_t'(exc1_mag_r);
    assign exc0_magnitude = adc_setup_pkg::exc_level_t'(exc0_mag_r);
    assign burnout_level = adc_setup_pkg::burnout_level_t'(burn_r);
    assign pos_ref_buffer_on = pos_buf_r;
    assign neg_ref_buffer_on = neg_buf_r;
    assign exc1_pin_select = exc1_pin_r;
    assign exc0_pin_select = exc0_pin_r;
    assign exc1_pin_reserved = exc1_rsv_r;
    assign exc0_pin_reserved = exc0_rsv_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_setup_roundtrip;
        ce && wr_en && addr == adc_setup_pkg::SETUP_BASE
            ##1 ce && rd_en && addr == adc_setup_pkg::SETUP_BASE
            |=> rd_data == $past(wr_data, 2);
    endproperty
    a_setup_roundtrip: assert property (p_setup_roundtrip)
        else $error("setup register did not read back written word");

    property p_last_setup_write;
        ce && wr_en && addr == adc_setup_pkg::SETUP_LAST |=> setup_r[7] == $past(wr_data);
    endproperty
    a_last_setup_write: assert property (p_last_setup_write)
        else $error("setup register at 0x20 not written");

    property p_exc1_pin_ain4;
        ce && chan_r[0][7:4] == 4'ha && !(wr_en && addr == 8'h09) |=> exc1_pin_select == 8'h10;
    endproperty
    a_exc1_pin_ain4: assert property (p_exc1_pin_ain4)
        else $error("pin code a did not route source 1 to input 4");

    property p_exc1_reserved;
        ce && chan_r[0][7:4] == 4'h2 |=> exc1_pin_select == 8'h00 && exc1_pin_reserved;
    endproperty
    a_exc1_reserved: assert property (p_exc1_reserved)
        else $error("reserved pin code drove a pin");

    property p_chanm_src0_reserved;
        ce && wr_en && addr == 8'h0a |=> chan_r[1][3:0] == 4'h0;
    endproperty
    a_chanm_src0_reserved: assert property (p_chanm_src0_reserved)
        else $error("source 0 field stored in a non-zero channel");

    property p_exc1_mag;
        ce |=> exc1_magnitude == $past(cur_cfg[15:13]);
    endproperty
    a_exc1_mag: assert property (p_exc1_mag)
        else $error("source 1 magnitude does not follow setup bits 15:13");

    property p_exc0_mag;
        ce ##1 !ce |=> exc0_magnitude == $past(cur_cfg[12:10], 2);
    endproperty
    a_exc0_mag: assert property (p_exc0_mag)
        else $error("source 0 magnitude lost while clock enable low");

    property p_burnout;
        ce |=> burnout_level == $past(cur_cfg[9:8]);
    endproperty
    a_burnout: assert property (p_burnout)
        else $error("burnout level does not follow setup bits 9:8");

    property p_pos_buf;
        ce && cur_cfg[7] |=> pos_ref_buffer_on;
    endproperty
    a_pos_buf: assert property (p_pos_buf)
        else $error("positive reference buffer not on");

    property p_neg_buf;
        ce && !cur_cfg[6] |=> !neg_ref_buffer_on;
    endproperty
    a_neg_buf: assert property (p_neg_buf)
        else $error("negative reference buffer not bypassed");

    property p_neg_buf_on;
        ce && cur_cfg[6] |=> neg_ref_buffer_on;
    endproperty
    a_neg_buf_on: assert property (p_neg_buf_on)
        else $error("negative reference buffer not on");

    property p_setup_stable;
        !(ce && wr_en) |=> $stable(setup_r) && $stable(chan_r);
    endproperty
    a_setup_stable: assert property (p_setup_stable)
        else $error("register changed without a write");

    property p_unmapped_read;
        ce && rd_en && addr == 8'h00 |=> rd_data == 16'h0000;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read returned non-zero");
endmodule

/* logic/adc_setup_pkg.sv */
// Constants and types for the ADC setup and excitation routing register bank.
// Assumes a single 100 MHz clock domain and a plain one-cycle register port.
package adc_setup_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int NUM_SETUPS = 8;
    localparam int NUM_CHANS = 8;
    localparam int NUM_PINS = 8;
    // Register offsets
    localparam logic [7:0] SETUP_BASE = 8'h19;
    localparam logic [7:0] SETUP_LAST = 8'h20;
    localparam logic [7:0] CHAN_BASE = 8'h09;
    localparam logic [7:0] CHAN_LAST = 8'h10;
    // Reset values
    localparam logic [15:0] SETUP_RST = 16'h0000;
    localparam logic [15:0] CHAN_RST = 16'h0000;
    localparam logic [15:0] READ_ZERO = 16'h0000;
    // Setup register fields
    localparam int EXC1_MAG_HI = 15;
    localparam int EXC1_MAG_LO = 13;
    localparam int EXC0_MAG_HI = 12;
    localparam int EXC0_MAG_LO = 10;
    localparam int BURNOUT_HI = 9;
    localparam int BURNOUT_LO = 8;
    localparam int POS_BUF_BIT = 7;
    localparam int NEG_BUF_BIT = 6;
    // Channel register fields
    localparam int SETUP_SEL_HI = 10;
    localparam int SETUP_SEL_LO = 8;
    localparam int EXC1_PIN_HI = 7;
    localparam int EXC1_PIN_LO = 4;
    localparam int EXC0_PIN_HI = 3;
    localparam int EXC0_PIN_LO = 0;
    localparam logic [15:0] CHAN0_MASK = 16'h07ff;
    localparam logic [15:0] CHANM_MASK = 16'h07f0;
    // Pin codes for analog inputs 0 to 7
    localparam logic [3:0] PIN_CODE_0 = 4'h0;
    localparam logic [3:0] PIN_CODE_1 = 4'h1;
    localparam logic [3:0] PIN_CODE_2 = 4'h4;
    localparam logic [3:0] PIN_CODE_3 = 4'h5;
    localparam logic [3:0] PIN_CODE_4 = 4'ha;
    localparam logic [3:0] PIN_CODE_5 = 4'hb;
    localparam logic [3:0] PIN_CODE_6 = 4'he;
    localparam logic [3:0] PIN_CODE_7 = 4'hf;

    typedef enum logic [2:0] {
        EXC_OFF = 3'h0,
        EXC_10UA = 3'h1,
        EXC_20UA = 3'h2,
        EXC_50UA = 3'h3,
        EXC_100UA = 3'h4,
        EXC_150UA = 3'h5,
        EXC_200UA = 3'h6,
        EXC_100NA = 3'h7
    } exc_level_t;

    typedef enum logic [1:0] {
        BURN_OFF = 2'h0,
        BURN_0P5UA = 2'h1,
        BURN_2UA = 2'h2,
        BURN_4UA = 2'h3
    } burnout_level_t;
endpackage

/* logic/pin_sel_if.sv */
// Carrier between the register bank and its pin-code decoder.
// Assumes the decoder is purely combinational.
`timescale 1ns/100ps
interface pin_sel_if;
    logic [3:0] code;
    logic [7:0] onehot;
    logic valid;
    modport dec
    (
        input code,
        output onehot,
        output valid
    );
    modport user
    (
        output code,
        input onehot,
        input valid
    );
endinterface

/* logic/pin_code_decoder.sv */
// Turns a 4-bit excitation pin code into a one-hot analog input select.
// Assumes the caller registers the result; reserved codes give no pin.
`timescale 1ns/100ps
module pin_code_decoder
(
    pin_sel_if.dec sel
);
    always_comb
    begin
        sel.valid = 1'b1;
        case (sel.code)
            adc_setup_pkg::PIN_CODE_0: sel.onehot = 8'h01;
            adc_setup_pkg::PIN_CODE_1: sel.onehot = 8'h02;
            adc_setup_pkg::PIN_CODE_2: sel.onehot = 8'h04;
            adc_setup_pkg::PIN_CODE_3: sel.onehot = 8'h08;
            adc_setup_pkg::PIN_CODE_4: sel.onehot = 8'h10;
            adc_setup_pkg::PIN_CODE_5: sel.onehot = 8'h20;
            adc_setup_pkg::PIN_CODE_6: sel.onehot = 8'h40;
            adc_setup_pkg::PIN_CODE_7: sel.onehot = 8'h80;
            // Reserved codes route the source nowhere
            default:
            begin
                sel.onehot = 8'h00;
                sel.valid = 1'b0;
            end
        endcase
    end
endmodule

/* test/tb.sv */
// Self-checking bench for the setup and excitation routing register bank.
// Assumes one-cycle strobes, read data one cycle later, outputs two cycles after a write.
`timescale 1ns/100ps
module tb;
    logic clock;
    logic rst;
    logic ce;
    logic [7:0] addr;
    logic [15:0] wr_data;
    logic wr_en;
    logic rd_en;
    logic [15:0] rd_data;
    logic [2:0] active_channel;
    adc_setup_pkg::exc_level_t exc1_magnitude;
    adc_setup_pkg::exc_level_t exc0_magnitude;
    adc_setup_pkg::burnout_level_t burnout_level;
    logic pos_ref_buffer_on;
    logic neg_ref_buffer_on;
    logic [7:0] exc1_pin_select;
    logic [7:0] exc0_pin_select;
    logic exc1_pin_reserved;
    logic exc0_pin_reserved;
    int num_errors;
    int checks;

    adc_setup_regs i_dut
    (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .addr(addr),
        .wr_data(wr_data),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .rd_data(rd_data),
        .active_channel(active_channel),
        .exc1_magnitude(exc1_magnitude),
        .exc0_magnitude(exc0_magnitude),
        .burnout_level(burnout_level),
        .pos_ref_buffer_on(pos_ref_buffer_on),
        .neg_ref_buffer_on(neg_ref_buffer_on),
        .exc1_pin_select(exc1_pin_select),
        .exc0_pin_select(exc0_pin_select),
        .exc1_pin_reserved(exc1_pin_reserved),
        .exc0_pin_reserved(exc0_pin_reserved)
    );

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Gap of one idle cycle between calls keeps strobes single-assigned
    task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask

    task automatic read_check(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        check(rd_data, exp);
    endtask

    // Outputs follow a register change one edge after the write edge
    task automatic settle;
        repeat (2) @(posedge clock);
        #1;
    endtask

    // Bit 8 flags a reserved code
    function automatic logic [8:0] pin_exp(input logic [3:0] c);
        case (c)
            4'h0: pin_exp = 9'h001;
            4'h1: pin_exp = 9'h002;
            4'h4: pin_exp = 9'h004;
            4'h5: pin_exp = 9'h008;
            4'ha: pin_exp = 9'h010;
            4'hb: pin_exp = 9'h020;
            4'he: pin_exp = 9'h040;
            4'hf: pin_exp = 9'h080;
            default: pin_exp = 9'h100;
        endcase
    endfunction

    initial
    begin
        repeat (100000) @(posedge clock);
        num_errors++;
        $display("mismatch at %0t: run did not finish", $time);
        report_and_stop;
    end

    initial
    begin
        logic [15:0] v;
        logic [8:0] e1;
        logic [8:0] e0;
        num_errors = 0;
        checks = 0;
        rst = 1'b1;
        ce = 1'b1;
        addr = 8'h00;
        wr_data = 16'h0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        active_channel = 3'h0;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++)
            read_check(adc_setup_pkg::SETUP_BASE + i[7:0], 16'h0000);
        read_check(adc_setup_pkg::CHAN_BASE, 16'h0000);
        settle;
        check({13'h0000, exc1_magnitude}, 16'h0000);
        check({8'h00, exc0_pin_select}, 16'h0001);
        $display("test reset_values done");

        for (int i = 0; i < 8; i++)
            write_reg(adc_setup_pkg::SETUP_BASE + i[7:0], {i[3:0], ~i[3:0], 8'h5a});
        for (int i = 0; i < 8; i++)
            read_check(adc_setup_pkg::SETUP_BASE + i[7:0], {i[3:0], ~i[3:0], 8'h5a});
        write_reg(8'h21, 16'hffff);
        read_check(8'h21, 16'h0000);
        read_check(8'h18, 16'h0000);
        read_check(adc_setup_pkg::SETUP_LAST, 16'h785a);
        @(posedge clock);
        #1;
        check(rd_data, 16'h0000);
        // Strobes with the clock enable low must be ignored
        ce <= 1'b0;
        write_reg(adc_setup_pkg::SETUP_BASE, 16'hbeef);
        ce <= 1'b1;
        read_check(adc_setup_pkg::SETUP_BASE, 16'h0f5a);
        // Write then read with no gap: the new word must come straight back
        @(posedge clock);
        addr <= adc_setup_pkg::SETUP_BASE;
        wr_data <= 16'h1234;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        check(rd_data, 16'h1234);
        read_check(8'h00, 16'h0000);
        $display("test register_access done");

        write_reg(adc_setup_pkg::CHAN_BASE, 16'h0000);
        for (int i = 0; i < 8; i++)
        begin
            v = {i[2:0], ~i[2:0], i[1:0], i[0], ~i[0], 6'h15};
            write_reg(adc_setup_pkg::SETUP_BASE, v);
            settle;
            check({13'h0000, exc1_magnitude}, {13'h0000, i[2:0]});
            check({13'h0000, exc0_magnitude}, {13'h0000, ~i[2:0]});
            check({14'h0000, burnout_level}, {14'h0000, i[1:0]});
            check({15'h0000, pos_ref_buffer_on}, {15'h0000, i[0]});
            check({15'h0000, neg_ref_buffer_on}, {15'h0000, ~i[0]});
        end
        $display("test setup_fields done");

        for (int c = 0; c < 16; c++)
        begin
            write_reg(adc_setup_pkg::CHAN_BASE, {8'h00, c[3:0], ~c[3:0]});
            settle;
            e1 = pin_exp(c[3:0]);
            e0 = pin_exp(~c[3:0]);
            check({7'h00, exc1_pin_reserved, exc1_pin_select}, {7'h00, e1});
            check({7'h00, exc0_pin_reserved, exc0_pin_select}, {7'h00, e0});
        end
        write_reg(adc_setup_pkg::CHAN_BASE + 8'h01, 16'hffff);
        read_check(adc_setup_pkg::CHAN_BASE + 8'h01, adc_setup_pkg::CHANM_MASK);
        write_reg(adc_setup_pkg::CHAN_BASE, 16'hffff);
        read_check(adc_setup_pkg::CHAN_BASE, adc_setup_pkg::CHAN0_MASK);
        $display("test pin_routing done");

        write_reg(adc_setup_pkg::SETUP_BASE + 8'h05, 16'ha480);
        write_reg(adc_setup_pkg::SETUP_BASE + 8'h02, 16'h4b00);
        write_reg(adc_setup_pkg::CHAN_BASE + 8'h01, 16'h0500);
        write_reg(adc_setup_pkg::CHAN_BASE + 8'h02, 16'h0500);
        write_reg(adc_setup_pkg::CHAN_BASE + 8'h03, 16'h0200);
        for (int ch = 1; ch < 4; ch++)
        begin
            active_channel <= ch[2:0];
            settle;
            check({13'h0000, exc1_magnitude}, (ch == 3) ? 16'h0002 : 16'h0005);
            check({14'h0000, burnout_level}, (ch == 3) ? 16'h0003 : 16'h0000);
            check({15'h0000, pos_ref_buffer_on}, (ch == 3) ? 16'h0000 : 16'h0001);
        end
        $display("test shared_setup done");
        report_and_stop;
    end
endmodule
